// file: src/sppm_pkg.sv
// constants for the serial port two pin-function select block
// assumes a 32-bit apb slave and four shared pins indexed a..d as 0..3
`default_nettype none

package sppm_pkg;

  // ****************************************************************
  // register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [11:0] SPPM_STAT_OFS = 12'h000; // held mode, read only
  localparam logic [11:0] SPPM_DIR_OFS  = 12'h004; // gpio direction
  localparam logic [11:0] SPPM_OUT_OFS  = 12'h008; // gpio output data
  localparam logic [11:0] SPPM_IN_OFS   = 12'h00c; // gpio pin levels

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int          SPPM_STAT_MODE_BIT = 0;     // 1: bsp functions
  localparam int          SPPM_GPIO_THREE    = 0;     // line three bit
  localparam int          SPPM_GPIO_FIVE     = 1;     // line five bit
  localparam int          SPPM_NPIN          = 4;     // shared pins
  localparam int          SPPM_PIN_UART_TX   = 1;     // pin b index
  localparam logic [1:0]  SPPM_DIR_RST       = 2'h0;  // gpio as inputs
  localparam logic [1:0]  SPPM_OUT_RST       = 2'h0;  // gpio data
  localparam logic        SPPM_UART_IDLE     = 1'h1;  // uart line idle
  localparam logic [31:0] SPPM_RDATA_RST     = 32'h0000_0000;

endpackage : sppm_pkg

`default_nettype wire

// file: src/sppm_strap_hold.sv
// strap capture: follows the strap pin while reset is low, then freezes
// assumes pclk runs while presetn is low
`default_nettype none

module sppm_strap_hold (
  input  wire logic pclk,          // system clock
  input  wire logic presetn,       // reset, active low
  input  wire logic mux_strap_pin, // board strap level
  output var  logic mode_bsp       // held choice, 1 selects bsp
);

  logic strap_ff;
  logic nxt_strap;

  // ****************************************************************
  // hold element
  // ****************************************************************
  // sampled only while reset is asserted, kept after the release
  always_comb begin
    nxt_strap = presetn ? strap_ff : mux_strap_pin; // R12 R5
  end

  // no async reset on purpose: the value is caught during reset
  always_ff @(posedge pclk) begin
    strap_ff <= nxt_strap;
  end

  assign mode_bsp = strap_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_strap_capture: assert property (@(posedge pclk) // R12
    !presetn |=> strap_ff == $past(mux_strap_pin))
    else $error("strap not captured during reset");

  a_strap_frozen: assert property (@(posedge pclk) // R5
    presetn |=> strap_ff == $past(strap_ff))
    else $error("held strap changed after reset");

endmodule : sppm_strap_hold

`default_nettype wire

// file: src/sppm_pin_select.sv
// pin-function select for the four shared pins of serial port two
// assumes a synchronous apb master, pad logic that resolves o/oe/i,
// and a uart and buffered serial port that sit beside this block
//
// Behaviour
// R1: strap low: pin c is gpio line five
// R2: strap high: pin c is bsp tx frame sync
// R3: strap low: pin d feeds uart receive
// R4: strap high: pin d is bsp rx frame sync
// R5: selection fixed at reset release, then kept
// R6: gpio line five is input after reset
// R7: bsp tx frame sync is input after reset
// R8: bsp rx frame sync is input after reset
// R9: pin a: gpio three, or bsp tx clock
// R10: pin b: uart transmit, or bsp rx clock
// R11: uart transmit drives one in reset
// R12: muxes steered by held strap, not live pin
`default_nettype none

module sppm_pin_select (
  input  wire logic        pclk,               // apb clock
  input  wire logic        presetn,            // async reset, active low
  input  wire logic        psel,               // apb select
  input  wire logic        penable,            // apb access phase
  input  wire logic        pwrite,             // apb direction
  input  wire logic [11:0] paddr,              // apb byte address
  input  wire logic [31:0] pwdata,             // apb write data
  output var  logic [31:0] prdata,             // apb read data
  output var  logic        pready,             // apb ready
  output var  logic        pslverr,            // apb error
  input  wire logic        mux_strap_pin,      // function strap
  input  wire logic        port_two_shared_pin_a_i, // pin a level
  output var  logic        port_two_shared_pin_a_o, // pin a drive
  output var  logic        port_two_shared_pin_a_oe, // pin a enable
  input  wire logic        port_two_shared_pin_b_i, // pin b level
  output var  logic        port_two_shared_pin_b_o, // pin b drive
  output var  logic        port_two_shared_pin_b_oe, // pin b enable
  input  wire logic        port_two_shared_pin_c_i, // pin c level
  output var  logic        port_two_shared_pin_c_o, // pin c drive
  output var  logic        port_two_shared_pin_c_oe, // pin c enable
  input  wire logic        port_two_shared_pin_d_i, // pin d level
  output var  logic        port_two_shared_pin_d_o, // pin d drive
  output var  logic        port_two_shared_pin_d_oe, // pin d enable
  input  wire logic        uart_txd,           // from uart transmitter
  output var  logic        uart_rxd,           // to uart receiver
  input  wire logic [3:0]  bsp_pin_out,        // bsp drive, per pin a..d
  input  wire logic [3:0]  bsp_pin_en,         // bsp enable, per pin a..d
  output var  logic [3:0]  bsp_pin_in          // pin levels to bsp
);

  logic       mode_bsp;
  logic [3:0] pin_i;
  logic [3:0] alt_o;
  logic [3:0] alt_oe;
  logic [3:0] pad_o_ff;
  logic [3:0] pad_oe_ff;
  logic [3:0] nxt_pad_o;
  logic [3:0] nxt_pad_oe;
  logic [1:0] gpio_dir_ff;
  logic [1:0] gpio_out_ff;
  logic [1:0] gpio_in_ff;
  logic [1:0] nxt_gpio_dir;
  logic [1:0] nxt_gpio_out;
  logic [1:0] nxt_gpio_in;
  logic [3:0] bsp_in_ff;
  logic [3:0] nxt_bsp_in;
  logic       uart_rxd_ff;
  logic       nxt_uart_rxd;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic       pready_ff;
  logic       nxt_pready;
  logic       pslverr_ff;
  logic       nxt_pslverr;
  logic       setup;
  logic       wr_done;
  logic       addr_ok;

  // ****************************************************************
  // strap hold
  // ****************************************************************
  sppm_strap_hold u_strap (
    .pclk          (pclk),
    .presetn       (presetn),
    .mux_strap_pin (mux_strap_pin),
    .mode_bsp      (mode_bsp)
  );

  // ****************************************************************
  // apb slave
  // ****************************************************************
  // decode in setup, answer in the first access cycle
  assign setup   = psel & ~penable;
  assign wr_done = psel & penable & pready_ff & pwrite;
  assign addr_ok = (paddr == sppm_pkg::SPPM_STAT_OFS) |
                   (paddr == sppm_pkg::SPPM_DIR_OFS)  |
                   (paddr == sppm_pkg::SPPM_OUT_OFS)  |
                   (paddr == sppm_pkg::SPPM_IN_OFS);

  // read mux, ready and error for the coming access phase
  always_comb begin
    nxt_pready  = setup;
    nxt_pslverr = setup & ~addr_ok;
    nxt_prdata  = sppm_pkg::SPPM_RDATA_RST;
    if (setup && !pwrite) begin
      case (paddr)
        sppm_pkg::SPPM_STAT_OFS:
          nxt_prdata[sppm_pkg::SPPM_STAT_MODE_BIT] = mode_bsp;
        sppm_pkg::SPPM_DIR_OFS: nxt_prdata[1:0] = gpio_dir_ff;
        sppm_pkg::SPPM_OUT_OFS: nxt_prdata[1:0] = gpio_out_ff;
        sppm_pkg::SPPM_IN_OFS:  nxt_prdata[1:0] = gpio_in_ff;
        default:                nxt_prdata      = sppm_pkg::SPPM_RDATA_RST;
      endcase
    end
  end

  // gpio registers; writes land at the completing edge
  always_comb begin
    nxt_gpio_dir = gpio_dir_ff;
    nxt_gpio_out = gpio_out_ff;
    if (wr_done && paddr == sppm_pkg::SPPM_DIR_OFS) begin
      nxt_gpio_dir = pwdata[1:0];
    end
    if (wr_done && paddr == sppm_pkg::SPPM_OUT_OFS) begin
      nxt_gpio_out = pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff   <= 1'b0;
      pslverr_ff  <= 1'b0;
      prdata_ff   <= sppm_pkg::SPPM_RDATA_RST;
      gpio_dir_ff <= sppm_pkg::SPPM_DIR_RST; // R6
      gpio_out_ff <= sppm_pkg::SPPM_OUT_RST;
    end else begin
      pready_ff   <= nxt_pready;
      pslverr_ff  <= nxt_pslverr;
      prdata_ff   <= nxt_prdata;
      gpio_dir_ff <= nxt_gpio_dir;
      gpio_out_ff <= nxt_gpio_out;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  // ****************************************************************
  // pad drive
  // ****************************************************************
  // strap-low functions: gpio three, uart tx, gpio five, uart rx
  assign alt_o  = {1'b0, gpio_out_ff[sppm_pkg::SPPM_GPIO_FIVE], uart_txd,
                   gpio_out_ff[sppm_pkg::SPPM_GPIO_THREE]};
  assign alt_oe = {1'b0, gpio_dir_ff[sppm_pkg::SPPM_GPIO_FIVE], 1'b1,
                   gpio_dir_ff[sppm_pkg::SPPM_GPIO_THREE]};

  // per pin: reset default, then bsp or alternate function
  for (genvar g = 0; g < sppm_pkg::SPPM_NPIN; g++) begin : g_pin
    always_comb begin
      if (!presetn) begin
        // only the uart tx pin drives in reset, and it drives one while the held strap is low
        nxt_pad_o[g]  = (g == sppm_pkg::SPPM_PIN_UART_TX) & ~mode_bsp; // R11
        nxt_pad_oe[g] = (g == sppm_pkg::SPPM_PIN_UART_TX) & ~mode_bsp; // R7 R8
      end else if (mode_bsp) begin
        nxt_pad_o[g]  = bsp_pin_out[g]; // R2 R4 R9 R10 R12
        nxt_pad_oe[g] = bsp_pin_en[g];
      end else begin
        nxt_pad_o[g]  = alt_o[g]; // R1 R3 R9 R10 R12
        nxt_pad_oe[g] = alt_oe[g];
      end
    end
  end

  // pad flops keep running in reset so the defaults reach the pins
  always_ff @(posedge pclk) begin
    pad_o_ff  <= nxt_pad_o;
    pad_oe_ff <= nxt_pad_oe;
  end

  assign port_two_shared_pin_a_o  = pad_o_ff[0];
  assign port_two_shared_pin_a_oe = pad_oe_ff[0];
  assign port_two_shared_pin_b_o  = pad_o_ff[1];
  assign port_two_shared_pin_b_oe = pad_oe_ff[1];
  assign port_two_shared_pin_c_o  = pad_o_ff[2];
  assign port_two_shared_pin_c_oe = pad_oe_ff[2];
  assign port_two_shared_pin_d_o  = pad_o_ff[3];
  assign port_two_shared_pin_d_oe = pad_oe_ff[3];

  // ****************************************************************
  // pad sense
  // ****************************************************************
  assign pin_i = {port_two_shared_pin_d_i, port_two_shared_pin_c_i,
                  port_two_shared_pin_b_i, port_two_shared_pin_a_i};

  // route pin levels to whichever function owns each pin
  always_comb begin
    nxt_bsp_in   = mode_bsp ? pin_i : 4'h0;
    nxt_uart_rxd = mode_bsp ? sppm_pkg::SPPM_UART_IDLE : pin_i[3]; // R3
    nxt_gpio_in  = mode_bsp ? 2'h0 : {pin_i[2], pin_i[0]}; // R1
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bsp_in_ff   <= 4'h0;
      uart_rxd_ff <= sppm_pkg::SPPM_UART_IDLE;
      gpio_in_ff  <= 2'h0;
    end else begin
      bsp_in_ff   <= nxt_bsp_in;
      uart_rxd_ff <= nxt_uart_rxd;
      gpio_in_ff  <= nxt_gpio_in;
    end
  end

  assign bsp_pin_in = bsp_in_ff;
  assign uart_rxd   = uart_rxd_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pin_c_gpio: assert property ( // R1
    $past(presetn) && !mode_bsp |-> port_two_shared_pin_c_o ==
      $past(gpio_out_ff[1]) && port_two_shared_pin_c_oe ==
      $past(gpio_dir_ff[1]))
    else $error("pin c not following gpio five");

  a_pin_c_bsp: assert property ( // R2
    $past(presetn) && mode_bsp |-> port_two_shared_pin_c_o ==
      $past(bsp_pin_out[2]) && port_two_shared_pin_c_oe ==
      $past(bsp_pin_en[2]))
    else $error("pin c not following bsp tx frame sync");

  a_pin_d_uart: assert property ( // R3
    $past(presetn) && !mode_bsp |=> uart_rxd ==
      $past(port_two_shared_pin_d_i) && !port_two_shared_pin_d_oe)
    else $error("pin d not feeding uart receive");

  a_pin_d_bsp: assert property ( // R4
    $past(presetn) && mode_bsp |=> bsp_pin_in[3] ==
      $past(port_two_shared_pin_d_i) && uart_rxd)
    else $error("pin d not feeding bsp rx frame sync");

  a_mode_kept: assert property ( // R5
    $past(presetn) |-> $stable(mode_bsp))
    else $error("function choice moved after reset");

  a_pin_a_func: assert property ( // R9
    $past(presetn) |-> port_two_shared_pin_a_oe == (mode_bsp ?
      $past(bsp_pin_en[0]) : $past(gpio_dir_ff[0])))
    else $error("pin a enable from wrong function");

  a_pin_b_func: assert property ( // R10
    $past(presetn) && !mode_bsp |-> port_two_shared_pin_b_oe &&
      port_two_shared_pin_b_o == $past(uart_txd))
    else $error("pin b not driving uart transmit");

  a_release_inputs: assert property (disable iff (1'b0) // R6
    $rose(presetn) |-> !port_two_shared_pin_a_oe &&
      !port_two_shared_pin_c_oe && !port_two_shared_pin_d_oe ##1
      gpio_dir_ff == 2'h0)
    else $error("pin not an input after reset");

  a_bsp_fs_inputs: assert property (disable iff (1'b0) // R7 R8
    !presetn && $past(!presetn) |-> !port_two_shared_pin_c_oe &&
      !port_two_shared_pin_d_oe)
    else $error("frame sync driven during reset");

  a_uart_tx_reset: assert property (disable iff (1'b0) // R11
    !presetn && $past(!presetn) && !$past(mode_bsp) |->
      port_two_shared_pin_b_o && port_two_shared_pin_b_oe)
    else $error("uart transmit not high in reset");

  a_apb_answer: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not in first access cycle");

  c_gpio_mode: cover property ($rose(presetn) ##1 !mode_bsp);
  c_bsp_mode: cover property ($rose(presetn) ##1 mode_bsp);
  c_dir_write: cover property (wr_done && paddr == sppm_pkg::SPPM_DIR_OFS);
  c_bad_addr: cover property (pslverr);

endmodule : sppm_pin_select

`default_nettype wire

// file: dv/sppm_far_model.sv
// far side of the shared pins: uart and bsp peers
// assumes pad o/oe from the device and a bench-driven far-side drive
`default_nettype none

module sppm_far_model (
  input  wire logic       pclk,   // sampling clock
  input  wire logic [3:0] pad_o,  // device drive, pins a..d
  input  wire logic [3:0] pad_oe, // device enable, pins a..d
  input  wire logic [3:0] ext_o,  // far-side drive
  input  wire logic [3:0] ext_oe, // far-side enable
  output var  logic [3:0] pin     // resolved pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // wire resolution
  // ****************************************************************
  logic [3:0] last_ff = 4'h0;

  // a pin nobody drives shows the inverse of its last level
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      pin[k] = pad_oe[k] ? pad_o[k] : (ext_oe[k] ? ext_o[k] : ~last_ff[k]);
    end
  end

  // remember the last level of each pin
  always_ff @(posedge pclk) begin
    last_ff <= pin;
  end
endmodule : sppm_far_model

`default_nettype wire

// file: dv/testbench.sv
// self-checking bench for the serial port two pin-function select
// assumes the far-side model resolves the four shared pins
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        strap = 0, uart_txd = 1, pready, pslverr, uart_rxd, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, rv;
  logic [3:0]  pad_o, pad_oe, pin, bsp_in;
  logic [3:0]  ext_o = 4'h0, ext_oe = 4'h0, bsp_out = 4'h0, bsp_en = 4'h0;
  int          n_errors = 0, n_compared = 0;

  // clock at 250 mhz
  always #2 pclk = ~pclk;

  sppm_pin_select u_sppm_pin_select (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mux_strap_pin(strap),
    .port_two_shared_pin_a_i(pin[0]), .port_two_shared_pin_a_o(pad_o[0]),
    .port_two_shared_pin_a_oe(pad_oe[0]),
    .port_two_shared_pin_b_i(pin[1]), .port_two_shared_pin_b_o(pad_o[1]),
    .port_two_shared_pin_b_oe(pad_oe[1]),
    .port_two_shared_pin_c_i(pin[2]), .port_two_shared_pin_c_o(pad_o[2]),
    .port_two_shared_pin_c_oe(pad_oe[2]),
    .port_two_shared_pin_d_i(pin[3]), .port_two_shared_pin_d_o(pad_o[3]),
    .port_two_shared_pin_d_oe(pad_oe[3]),
    .uart_txd(uart_txd), .uart_rxd(uart_rxd), .bsp_pin_out(bsp_out),
    .bsp_pin_en(bsp_en), .bsp_pin_in(bsp_in));

  sppm_far_model u_sppm_far_model (
    .pclk(pclk), .pad_o(pad_o), .pad_oe(pad_oe), .ext_o(ext_o),
    .ext_oe(ext_oe), .pin(pin));

  // ****************************************************************
  // tasks
  // ****************************************************************
  // verdict and end of run
  task automatic conclude();
    $display("counts: %0d compared, %0d mismatched", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, answer taken at the ready edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (t >= 20) begin
      n_errors++;
      $display("BAD %0t no ready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // let one edge pass and its updates land
  task automatic tick();
    @(posedge pclk);
    #1;
  endtask : tick

  // ten reset cycles, strap wanders then settles at s
  task automatic do_reset(input logic s);
    @(posedge pclk);
    presetn <= 1'b0;
    for (int k = 0; k < 10; k++) begin
      strap <= (k < 8) ? 1'($urandom) : s;
      @(posedge pclk);
    end
    presetn <= 1'b1;
    strap <= ~s;
    #1;
    chk(pad_oe, {2'h0, ~s, 1'b0});
    chk(pad_o[1] | s, 1'b1);
  endtask : do_reset

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    rv = $urandom(54);
    do_reset(1'b0);
    apb(1'b0, sppm_pkg::SPPM_STAT_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, sppm_pkg::SPPM_DIR_OFS, 32'h0);
    chk(rd, 32'(sppm_pkg::SPPM_DIR_RST));
    repeat (16) begin
      @(posedge pclk);
      uart_txd <= 1'($urandom);
      bsp_out <= 4'($urandom);
      bsp_en <= 4'($urandom);
      ext_o <= 4'($urandom);
      ext_oe <= 4'hd;
      strap <= 1'($urandom);
      tick();
      chk(pad_oe, 4'h2);
      chk(pad_o[1], uart_txd);
      tick();
      chk(uart_rxd, ext_o[3]);
      chk(bsp_in, 4'h0);
    end
    rv = $urandom;
    ext_oe <= 4'h8;
    apb(1'b1, sppm_pkg::SPPM_DIR_OFS, 32'h3);
    apb(1'b1, sppm_pkg::SPPM_OUT_OFS, rv & 32'h3);
    tick();
    tick();
    chk({pad_oe[2], pad_oe[0]}, 2'h3);
    chk({pad_o[2], pad_o[0]}, rv[1:0]);
    apb(1'b0, sppm_pkg::SPPM_OUT_OFS, 32'h0);
    chk(rd, rv & 32'h3);
    apb(1'b1, sppm_pkg::SPPM_DIR_OFS, 32'h0);
    ext_oe <= 4'hd;
    tick();
    tick();
    apb(1'b0, sppm_pkg::SPPM_IN_OFS, 32'h0);
    chk(rd, {30'h0, ext_o[2], ext_o[0]});
    apb(1'b1, sppm_pkg::SPPM_STAT_OFS, 32'h1);
    apb(1'b0, sppm_pkg::SPPM_STAT_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    $display("test mode_low done");
    bsp_en <= 4'h0;
    do_reset(1'b1);
    tick();
    chk(pad_oe, 4'h0);
    chk(uart_rxd, 1'b1);
    apb(1'b0, sppm_pkg::SPPM_STAT_OFS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, sppm_pkg::SPPM_DIR_OFS, 32'h3);
    repeat (24) begin
      @(posedge pclk);
      rv = $urandom;
      bsp_out <= rv[3:0];
      bsp_en <= rv[7:4];
      ext_oe <= ~rv[7:4];
      ext_o <= rv[11:8];
      uart_txd <= rv[12];
      strap <= rv[13];
      tick();
      chk(pad_oe, bsp_en);
      chk(pad_o & bsp_en, bsp_out & bsp_en);
      tick();
      chk(bsp_in, (bsp_out & bsp_en) | (ext_o & ~bsp_en));
      chk(uart_rxd, 1'b1);
    end
    $display("test mode_high done");
    conclude();
  end

  // watchdog against a hung transfer
  initial begin
    #80000;
    n_errors++;
    conclude();
  end
endmodule : testbench

`default_nettype wire
